// *** design/aspi_pkg.sv ***
// constants and shared types for the serial port block
// Function
// - idle level high NRZ, low infra-red
// - frame start, data, parity, stop bits
// - eight-byte tx queue, empty irq rearms
// - tx half when fewer than four
// - tx avail while a free slot
// - cts high holds next character
// - break request forces continuous zeros
// - transmitter shifts on bit clock
// - infra-red zero is 3/16 pulse in 16x, whole bit in 1x
// - 16x hunt, qualify, centre majority vote
// - 1x samples on bit clock rise
// - shift data, parity, stop; flag errors
// - word read returns status and byte
// - rts hardware-driven or software bit
// - rx full when one slot left
// - rx half once four entered
// - rx ready when any character held
// - infra-red rx decodes pulse as zero
// - prescaler then power-of-two divider, source select
// - taps 1..128, divide by 16
// - irq is OR of six masked sources
// - enable low gates internal activity
// - odd when set, even when clear
// - two stop bits when set
// - seven-bit mode drops bit seven
// - direction disable flushes its queue
package aspi_pkg;
	localparam int DEPTH = 8;
	localparam int PTR_W = 3;
	localparam logic [3:0] CNT_FULL = 4'h8;
	localparam logic [3:0] CNT_HALF = 4'h4;
	localparam logic [3:0] CNT_RXFULL = 4'h7;
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_BAUD = 3'h1;
	localparam logic [2:0] ADDR_RX = 3'h2;
	localparam logic [2:0] ADDR_TX = 3'h3;
	localparam logic [2:0] ADDR_MISC = 3'h4;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] BAUD_RST = 16'h003F;
	localparam logic [15:0] MISC_RST = 16'h0000;
	// control register fields
	localparam int C_EN = 15;
	localparam int C_RXEN = 14;
	localparam int C_TXEN = 13;
	localparam int C_1X = 12;
	localparam int C_PAR = 11;
	localparam int C_ODD = 10;
	localparam int C_STOP2 = 9;
	localparam int C_8BIT = 8;
	// baud register fields
	localparam int B_SRC = 11;
	localparam int B_DIV_HI = 10;
	localparam int B_DIV_LO = 8;
	localparam int B_PRE_HI = 5;
	localparam int B_PRE_LO = 0;
	// misc register fields
	localparam int M_BREAK = 0;
	localparam int M_NOCTS = 1;
	localparam int M_RTSSW = 2;
	localparam int M_RTSBIT = 3;
	localparam int M_IRDA = 4;
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_MID = 4'h7;
	localparam logic [3:0] IR_PULSE = 4'h3;
	typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} aspi_tx_t;
	typedef enum logic [1:0] {RX_HUNT, RX_START, RX_BITS} aspi_rx_t;
endpackage

// *** design/aspi_fifo.sv ***
// eight-entry W-bit queue in flip-flops
`timescale 1ns/1ps
module aspi_fifo
	import aspi_pkg::*;
#(
	parameter int W = 8
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic push,
	input wire logic [W-1:0] wdata,
	input wire logic pop,
	output logic [W-1:0] rdata,
	output logic [3:0] count
);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [3:0] cnt_q, cnt_d;
	logic do_push, do_pop;

	always_comb begin
		do_push = push && (cnt_q != CNT_FULL);
		do_pop = pop && (cnt_q != 4'h0);
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		for (int i = 0; i < DEPTH; i++) begin
			mem_d[i] = mem_q[i];
		end
		if (flush) begin
			wp_d = '0;
			rp_d = '0;
			cnt_d = 4'h0;
		end else begin
			if (do_push) begin
				mem_d[wp_q] = wdata;
				wp_d = wp_q + 3'h1;
			end
			if (do_pop) begin
				rp_d = rp_q + 3'h1;
			end
			cnt_d = cnt_q + {3'h0, do_push} - {3'h0, do_pop};
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= 4'h0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
		for (int i = 0; i < DEPTH; i++) begin
			mem_q[i] <= mem_d[i];
		end
	end

	assign rdata = mem_q[rp_q];
	assign count = cnt_q;

	a_fifo_bound: assert property (@(posedge mclk) disable iff (!rst_n) cnt_q <= CNT_FULL)
		else $error("queue count above depth");
endmodule

// *** design/aspi_top.sv ***
// serial port with queues, flow control, infra-red mode and baud generator
//
// Our own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module aspi_top
	import aspi_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	output logic txd,
	input wire logic rxd,
	input wire logic cts_n,
	output logic rts_n,
	input wire logic gpio_in,
	output logic irq
);
	// pin synchronisers
	logic [1:0] rxd_s_q, cts_s_q, gpio_s_q;
	logic rxd_i, cts_i, gpio_last_q;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxd_s_q <= 2'h3;
			cts_s_q <= 2'h3;
			gpio_s_q <= 2'h0;
			gpio_last_q <= 1'b0;
		end else begin
			rxd_s_q <= {rxd_s_q[0], rxd};
			cts_s_q <= {cts_s_q[0], cts_n};
			gpio_s_q <= {gpio_s_q[0], gpio_in};
			gpio_last_q <= gpio_s_q[1];
		end
	end
	assign cts_i = cts_s_q[1];

	// registers
	logic [15:0] ctrl_q, ctrl_d, baud_q, baud_d, misc_q, misc_d, rdata_q, rdata_d;
	logic en, rxen, txen, irda;
	assign en = ctrl_q[C_EN];
	assign rxen = en && ctrl_q[C_RXEN];
	assign txen = en && ctrl_q[C_TXEN];
	assign irda = misc_q[M_IRDA];
	assign rxd_i = irda ? ~rxd_s_q[1] : rxd_s_q[1];

	// baud generator: prescaler then 2^n divider
	logic [5:0] pre_q, pre_d;
	logic [7:0] div_q, div_d;
	logic [3:0] sub_q, sub_d;
	logic src_tick, pre_tick, os_tick, bit_tick, os_mode;
	logic [7:0] div_next;
	always_comb begin
		src_tick = baud_q[B_SRC] ? (gpio_s_q[1] && !gpio_last_q) : 1'b1;
		pre_tick = src_tick && (pre_q == 6'h0);
		pre_d = pre_q;
		div_d = div_q;
		sub_d = sub_q;
		div_next = div_q + 8'h01;
		os_tick = 1'b0;
		if (!en) begin
			pre_d = 6'h0;
			div_d = 8'h00;
			sub_d = 4'h0;
		end else if (src_tick) begin
			pre_d = pre_tick ? baud_q[B_PRE_HI:B_PRE_LO] : pre_q - 6'h01;
			if (pre_tick) begin
				div_d = div_next;
				// tap 2^n fires each time the low n counter bits wrap to zero
				os_tick = (div_next & ((8'h01 << baud_q[B_DIV_HI:B_DIV_LO]) - 8'h01)) == 8'h00;
			end
		end
		if (os_tick) begin
			sub_d = sub_q + 4'h1;
		end
		os_mode = ctrl_q[C_1X];
		bit_tick = os_tick && (os_mode || (sub_q == OS_LAST));
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			pre_q <= 6'h0;
			div_q <= 8'h00;
			sub_q <= 4'h0;
		end else begin
			pre_q <= pre_d;
			div_q <= div_d;
			sub_q <= sub_d;
		end
	end

	// queues
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic [7:0] tx_head, rx_byte;
	logic [11:0] rx_head, rx_word;
	logic [3:0] tx_cnt, rx_cnt;
	aspi_fifo #(.W(8)) u_txq (.mclk(mclk), .rst_n(rst_n), .flush(!txen), .push(tx_push),
		.wdata(wdata[7:0]), .pop(tx_pop), .rdata(tx_head), .count(tx_cnt));
	aspi_fifo #(.W(12)) u_rxq (.mclk(mclk), .rst_n(rst_n), .flush(!rxen), .push(rx_push),
		.wdata(rx_word), .pop(rx_pop), .rdata(rx_head), .count(rx_cnt));

	// transmitter
	aspi_tx_t tx_st_q, tx_st_d;
	logic [11:0] tx_sh_q, tx_sh_d;
	logic [3:0] tx_left_q, tx_left_d, tx_ph_q, tx_ph_d;
	logic txd_q, txd_d, tx_par;
	logic [7:0] tx_data;
	always_comb begin
		tx_st_d = tx_st_q;
		tx_sh_d = tx_sh_q;
		tx_left_d = tx_left_q;
		tx_ph_d = tx_ph_q;
		tx_pop = 1'b0;
		tx_data = {tx_head[7] & ctrl_q[C_8BIT], tx_head[6:0]};
		tx_par = (^tx_data) ^ ctrl_q[C_ODD];
		if (os_tick) begin
			tx_ph_d = tx_ph_q + 4'h1;
		end
		unique case (tx_st_q)
			TX_IDLE: begin
				// cts only gates a new character, never one in flight
				if (bit_tick && txen && tx_cnt != 4'h0 && (!cts_i || misc_q[M_NOCTS])) begin
					tx_pop = 1'b1;
					tx_ph_d = 4'h0;
					tx_st_d = TX_SHIFT;
					// lsb first: start, data, parity, stops; ones fill the tail
					if (ctrl_q[C_8BIT]) begin
						tx_sh_d = ctrl_q[C_PAR] ? {2'h3, tx_par, tx_data, 1'b0} : {3'h7, tx_data, 1'b0};
					end else begin
						tx_sh_d = ctrl_q[C_PAR] ? {3'h7, tx_par, tx_data[6:0], 1'b0} : {4'hF, tx_data[6:0], 1'b0};
					end
					tx_left_d = 4'h9 + {3'h0, ctrl_q[C_8BIT]} + {3'h0, ctrl_q[C_PAR]} + {3'h0, ctrl_q[C_STOP2]};
				end
			end
			TX_SHIFT: begin
				if (bit_tick) begin
					tx_ph_d = 4'h0;
					tx_sh_d = {1'b1, tx_sh_q[11:1]};
					tx_left_d = tx_left_q - 4'h1;
					if (tx_left_q == 4'h1) begin
						tx_st_d = TX_IDLE;
					end
				end
			end
		endcase
		if (!txen) begin
			tx_st_d = TX_IDLE;
		end
		if (misc_q[M_BREAK]) begin
			txd_d = irda;
		end else if (tx_st_q == TX_IDLE) begin
			txd_d = !irda;
		end else if (irda) begin
			txd_d = !tx_sh_q[0] && (tx_ph_q < IR_PULSE);
		end else begin
			txd_d = tx_sh_q[0];
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			tx_st_q <= TX_IDLE;
			tx_sh_q <= 12'hFFF;
			tx_left_q <= 4'h0;
			tx_ph_q <= 4'h0;
			txd_q <= 1'b1;
		end else begin
			tx_st_q <= tx_st_d;
			tx_sh_q <= tx_sh_d;
			tx_left_q <= tx_left_d;
			tx_ph_q <= tx_ph_d;
			txd_q <= txd_d;
		end
	end

	// receiver
	aspi_rx_t rx_st_q, rx_st_d;
	logic [3:0] rx_os_q, rx_os_d, rx_n_q, rx_n_d;
	logic [2:0] vote_q, vote_d;
	logic [8:0] rx_sh_q, rx_sh_d;
	logic ir_seen_q, ir_seen_d, samp, rx_last_q;
	logic [3:0] rx_bits;
	logic perr, ferr, brk;
	logic [8:0] rx_al;
	always_comb begin
		rx_st_d = rx_st_q;
		rx_os_d = rx_os_q;
		rx_n_d = rx_n_q;
		vote_d = vote_q;
		rx_sh_d = rx_sh_q;
		ir_seen_d = ir_seen_q | (irda & rxd_i == 1'b0);
		rx_push = 1'b0;
		rx_bits = 4'h8 + {3'h0, ctrl_q[C_PAR]} - {3'h0, !ctrl_q[C_8BIT]};
		// majority of three samples around the bit centre
		samp = (vote_q[0] & vote_q[1]) | (vote_q[0] & vote_q[2]) | (vote_q[1] & vote_q[2]);
		if (irda) begin
			samp = !ir_seen_q;
		end
		if (ctrl_q[C_1X]) begin
			samp = irda ? !ir_seen_q : rxd_i;
		end
		// shorter frames stop higher in the shifter: bring data down to bit 0, parity above it
		rx_al = rx_sh_q >> (4'h9 - rx_bits);
		perr = ctrl_q[C_PAR] && ((^rx_al) ^ ctrl_q[C_ODD]);
		ferr = !samp;
		brk = ferr && (rx_sh_q == 9'h000);
		rx_word = {perr & !brk, ferr, brk, 1'b0,
			(ctrl_q[C_8BIT] ? rx_al[7] : 1'b0), rx_al[6:0]};
		if (os_tick) begin
			rx_os_d = rx_os_q + 4'h1;
			if (rx_os_q >= OS_MID - 4'h1 && rx_os_q <= OS_MID + 4'h1) begin
				vote_d = {vote_q[1:0], rxd_i};
			end
		end
		unique case (rx_st_q)
			RX_HUNT: begin
				rx_os_d = 4'h0;
				rx_sh_d = 9'h000;
				ir_seen_d = 1'b0;
				if (rxen && (ctrl_q[C_1X] ? bit_tick && !rxd_i : os_tick && !rxd_i)) begin
					rx_st_d = ctrl_q[C_1X] ? RX_BITS : RX_START;
					rx_n_d = 4'h0;
				end
			end
			RX_START: begin
				if (os_tick && rx_os_q == OS_LAST) begin
					rx_st_d = samp ? RX_HUNT : RX_BITS; // false start rejected
					ir_seen_d = 1'b0;
				end
			end
			RX_BITS: begin
				if (ctrl_q[C_1X] ? bit_tick : (os_tick && rx_os_q == OS_LAST)) begin
					ir_seen_d = 1'b0;
					if (rx_n_q == rx_bits) begin
						rx_push = 1'b1;
						rx_st_d = RX_HUNT;
					end else begin
						rx_sh_d = {samp, rx_sh_q[8:1]};
						rx_n_d = rx_n_q + 4'h1;
					end
				end
			end
			default: rx_st_d = RX_HUNT;
		endcase
		if (!rxen) begin
			rx_st_d = RX_HUNT;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rx_st_q <= RX_HUNT;
			rx_os_q <= 4'h0;
			rx_n_q <= 4'h0;
			vote_q <= 3'h7;
			rx_sh_q <= 9'h000;
			ir_seen_q <= 1'b0;
		end else begin
			rx_st_q <= rx_st_d;
			rx_os_q <= rx_os_d;
			rx_n_q <= rx_n_d;
			vote_q <= vote_d;
			rx_sh_q <= rx_sh_d;
			ir_seen_q <= ir_seen_d;
		end
	end

	// register port and interrupt sources
	logic tx_empty_arm_q, tx_empty_arm_d, rts_d, rts_q, irq_d, irq_q, rx_half_d;
	logic [7:0] src;
	always_comb begin
		ctrl_d = ctrl_q;
		baud_d = baud_q;
		misc_d = misc_q;
		tx_push = wr && addr == ADDR_TX && txen;
		rx_pop = rd && addr == ADDR_RX;
		if (wr) begin
			unique case (addr)
				ADDR_CTRL: ctrl_d = wdata;
				ADDR_BAUD: baud_d = wdata;
				ADDR_MISC: misc_d = wdata;
				default: ;
			endcase
		end
		rx_half_d = rx_cnt >= CNT_HALF;
		// empty fires once, then waits until the queue refills and drains
		tx_empty_arm_d = tx_empty_arm_q;
		if (tx_cnt != 4'h0) begin
			tx_empty_arm_d = 1'b1;
		end else if (tx_empty_arm_q && tx_push == 1'b0) begin
			tx_empty_arm_d = tx_empty_arm_q;
		end
		src[0] = tx_cnt != CNT_FULL;
		src[1] = tx_cnt < CNT_HALF;
		src[2] = tx_cnt == 4'h0 && tx_empty_arm_q;
		src[3] = rx_cnt != 4'h0;
		src[4] = rx_half_d;
		src[5] = rx_cnt >= CNT_RXFULL;
		src[6] = 1'b0;
		src[7] = 1'b0;
		irq_d = en && |(src & ctrl_q[7:0]);
		rts_d = misc_q[M_RTSSW] ? misc_q[M_RTSBIT] : !(rxen && rx_cnt < CNT_RXFULL);
		unique case (addr)
			ADDR_CTRL: rdata_d = ctrl_q;
			ADDR_BAUD: rdata_d = {baud_q[15], gpio_s_q[1], baud_q[13:0]};
			ADDR_RX: rdata_d = {rx_cnt != 4'h0, rx_cnt >= CNT_RXFULL, rx_half_d, rx_head[11:8], 1'b0, rx_head[7:0]};
			ADDR_TX: rdata_d = {tx_cnt == 4'h0, tx_cnt < CNT_HALF, tx_cnt != CNT_FULL, 4'h0, cts_i, 8'h00};
			ADDR_MISC: rdata_d = misc_q;
			default: rdata_d = 16'h0000;
		endcase
		if (!rd) begin
			rdata_d = 16'h0000;
		end
	end
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctrl_q <= CTRL_RST;
			baud_q <= BAUD_RST;
			misc_q <= MISC_RST;
			rdata_q <= 16'h0000;
			tx_empty_arm_q <= 1'b1;
			rts_q <= 1'b1;
			irq_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			baud_q <= baud_d;
			misc_q <= misc_d;
			rdata_q <= rdata_d;
			tx_empty_arm_q <= (tx_cnt == 4'h0 && !tx_push) ? 1'b0 : tx_empty_arm_d;
			rts_q <= rts_d;
			irq_q <= irq_d;
		end
	end
	assign rdata = rdata_q;
	assign txd = txd_q;
	assign rts_n = rts_q;
	assign irq = irq_q;

	a_idle_level: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(tx_st_q == TX_IDLE && !misc_q[M_BREAK]) |-> txd == !$past(irda))
		else $error("idle level wrong");
	a_break_zero: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(misc_q[M_BREAK]) |-> txd == $past(irda))
		else $error("break not driven");
	a_cts_hold: assert property (@(posedge mclk) disable iff (!rst_n)
		(tx_st_q == TX_IDLE && cts_i && !misc_q[M_NOCTS]) |=> tx_st_q == TX_IDLE)
		else $error("character started with cts high");
	a_tx_avail: assert property (@(posedge mclk) disable iff (!rst_n)
		src[0] == (tx_cnt < CNT_FULL))
		else $error("avail flag wrong");
	a_rx_full: assert property (@(posedge mclk) disable iff (!rst_n)
		(rx_cnt == 4'h7) |-> src[5])
		else $error("rx full missing");
	a_irq_or: assert property (@(posedge mclk) disable iff (!rst_n)
		irq == $past(en && |(src & ctrl_q[7:0])))
		else $error("irq not or of sources");
	a_flush_tx: assert property (@(posedge mclk) disable iff (!rst_n)
		$past(!txen) |-> tx_cnt == 4'h0)
		else $error("tx queue not flushed");
	a_gate_off: assert property (@(posedge mclk) disable iff (!rst_n)
		!en |-> !os_tick)
		else $error("ticks while disabled");
endmodule

// *** bench/aspi_partner.sv ***
// far-end serial station: sends frames on rxd, captures frames from txd, drives flow control
`timescale 1ns/1ps
module aspi_partner #(
	parameter int BIT = 16
) (
	input wire logic mclk,
	input wire logic txd,
	output logic rxd,
	output logic cts_n,
	input wire logic rts_n
);
	logic [9:0] cap_q[$];
	logic [9:0] sh;

	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
	end

	// remote side owns clear-to-send
	task automatic hold(input logic v);
		cts_n <= v;
	endtask

	// lsb first after a low start bit, nrz levels only
	task automatic send(input logic [10:0] f);
		// a polite far end waits for request-to-send low
		for (int w = 0; w < 5000 && rts_n !== 1'b0; w++) @(posedge mclk);
		for (int i = 0; i < 11; i++) begin
			rxd <= f[i];
			repeat (BIT) @(posedge mclk);
		end
	endtask

	// mid-bit sampling; ten bits after start, so one-stop frames sent back to back would clip
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge mclk);
		if (txd === 1'b0) begin
			for (int i = 0; i < 10; i++) begin
				repeat (BIT) @(posedge mclk);
				sh[i] = txd;
			end
			cap_q.push_back(sh);
		end
	end
endmodule

// *** bench/tb_async_serial_port_irda.sv ***
// self-checking bench for the serial port block
`timescale 1ns/1ps
module tb_async_serial_port_irda;
	import aspi_pkg::*;
	logic mclk, rst_n, wr, rd, gpio_in, txd, rxd, cts_n, rts_n, irq, a, fl, gpio_run;
	logic [2:0] addr;
	logic [15:0] wdata, rdata, r, cf;
	logic [7:0] d;
	logic [9:0] c;
	logic [10:0] f;
	logic [7:0] q[$];
	int n_mismatch, n_compared, seed, rv, k, cnt;

	aspi_top uut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .txd(txd), .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n), .gpio_in(gpio_in), .irq(irq));
	aspi_partner u_far (.mclk(mclk), .txd(txd), .rxd(rxd), .cts_n(cts_n), .rts_n(rts_n));

	// external baud clock: toggles every edge while enabled, so one rising edge per two cycles
	always @(posedge mclk) gpio_in <= gpio_run & ~gpio_in;

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	// strobe held for one edge, then one idle edge so strobes never double-assign
	task automatic wreg(input logic [2:0] ad, input logic [15:0] dv);
		addr <= ad;
		wdata <= dv;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic rreg(input logic [2:0] ad, output logic [15:0] dv);
		addr <= ad;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 dv = rdata;
		@(posedge mclk);
	endtask

	// n below zero waits for irq, otherwise for n captured frames
	task automatic wait_on(input int n);
		int w;
		for (w = 0; w < 4000; w++) begin
			if (n < 0 ? irq === 1'b1 : u_far.cap_q.size() >= n) break;
			@(posedge mclk);
		end
		if (w == 4000) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: wait ran out", $time);
			give_verdict();
		end
	endtask

	task automatic count_high(input int n);
		cnt = 0;
		repeat (n) begin
			@(posedge mclk);
			if (txd === 1'b1) cnt++;
		end
	endtask

	// start bit, data (7 or 8), optional parity, then ones; flip spoils the parity
	function automatic logic [10:0] frm(input logic [7:0] dv, input logic p_en, input logic odd,
		input logic b8, input logic flip);
		logic [10:0] fr;
		fr = '1;
		if (b8) fr[7:0] = dv;
		else fr[6:0] = dv[6:0];
		if (p_en) fr[b8 ? 8 : 7] = (b8 ? ^dv : ^dv[6:0]) ^ odd ^ flip;
		return {fr[9:0], 1'b0};
	endfunction

	initial begin
		seed = 29;
		rst_n = 1'b0;
		addr = 3'h0;
		wdata = 16'h0000;
		wr = 1'b0;
		rd = 1'b0;
		gpio_run = 1'b0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		rreg(ADDR_CTRL, r);
		chk(r, CTRL_RST, "ctrl reset");
		rreg(ADDR_BAUD, r);
		chk(r, BAUD_RST, "baud reset");
		rreg(3'h5, r);
		chk(r, 16'h0000, "unmapped read");
		chk({15'h0, txd}, 16'h0001, "nrz idle");
		wreg(ADDR_BAUD, 16'h0000);
		// every parity, sense and length mode both ways; one spoiled parity
		for (int m = 0; m < 8; m++) begin
			cf = 16'hE008;
			cf[C_PAR] = m[0];
			cf[C_ODD] = m[1];
			cf[C_8BIT] = m[2];
			fl = (m == 3);
			wreg(ADDR_CTRL, cf);
			u_far.cap_q.delete();
			rv = $random(seed);
			d = rv[7:0];
			f = frm(d, m[0], m[1], m[2], 1'b0);
			wreg(ADDR_TX, {8'h00, d});
			wait_on(1);
			c = u_far.cap_q.pop_front();
			chk({6'h0, c}, {6'h0, f[10:1]}, "tx frame");
			rv = $random(seed);
			d = rv[7:0];
			u_far.send(frm(d, m[0], m[1], m[2], fl));
			wait_on(-1);
			rreg(ADDR_RX, r);
			chk(r, {1'b1, 2'b00, fl, 4'h0, m[2] ? d[7] : 1'b0, d[6:0]}, "rx word");
			repeat (3) @(posedge mclk);
		end
		chk({15'h0, rts_n}, 16'h0000, "rts ready");
		// queue levels while flow control holds the line
		wreg(ADDR_CTRL, 16'hE301);
		u_far.hold(1'b1);
		repeat (4) @(posedge mclk);
		u_far.cap_q.delete();
		for (int i = 0; i < 9; i++) begin
			rv = $random(seed);
			if (i < 8) q.push_back(rv[7:0]);
			wreg(ADDR_TX, {8'h00, rv[7:0]});
			rreg(ADDR_TX, r);
			k = (i > 7) ? 8 : i + 1;
			chk({13'h0, r[15:13]}, {13'h0, 1'b0, k < 4, k < 8}, "tx level");
		end
		chk({15'h0, irq}, 16'h0000, "avail irq when full");
		count_high(100);
		chk(cnt[15:0], 16'd100, "held by cts");
		u_far.hold(1'b0);
		wait_on(8);
		repeat (300) @(posedge mclk);
		chk(16'(u_far.cap_q.size()), 16'd8, "ninth byte dropped");
		foreach (q[i]) begin
			c = u_far.cap_q.pop_front();
			chk({6'h0, c}, {6'h0, 2'b11, q[i]}, "burst order");
		end
		rreg(ADDR_TX, r);
		chk({13'h0, r[15:13]}, 16'h0007, "tx drained");
		chk({15'h0, irq}, 16'h0001, "avail irq");
		// disable flushes the queue
		u_far.hold(1'b1);
		repeat (4) @(posedge mclk);
		repeat (3) wreg(ADDR_TX, 16'h0055);
		wreg(ADDR_CTRL, 16'hC300);
		wreg(ADDR_CTRL, 16'hE300);
		rreg(ADDR_TX, r);
		chk({15'h0, r[15]}, 16'h0001, "flushed empty");
		u_far.hold(1'b0);
		repeat (300) @(posedge mclk);
		chk(16'(u_far.cap_q.size()), 16'd0, "nothing sent");
		// break
		wreg(ADDR_MISC, 16'h0001);
		count_high(64);
		chk(cnt[15:0], 16'd0, "break zeros");
		wreg(ADDR_MISC, 16'h0000);
		// infra-red: low idle, 3-cycle pulse per zero bit
		wreg(ADDR_CTRL, 16'hE100);
		wreg(ADDR_MISC, 16'h0010);
		repeat (200) @(posedge mclk);
		chk({15'h0, txd}, 16'h0000, "ir idle");
		u_far.hold(1'b1);
		wreg(ADDR_TX, 16'h0000);
		u_far.hold(1'b0);
		count_high(240);
		chk(cnt[15:0], 16'd27, "ir pulses");
		// software-driven request-to-send
		wreg(ADDR_MISC, 16'h000C);
		repeat (3) @(posedge mclk);
		a = rts_n;
		wreg(ADDR_MISC, 16'h0004);
		repeat (3) @(posedge mclk);
		chk({14'h0, a, rts_n}, 16'h0002, "rts follows bit");
		// gpio source, divide-by-two tap, then 1x: a zero byte keeps txd low for nine bit times
		gpio_run <= 1'b1;
		for (int b = 0; b < 3; b++) begin
			wreg(ADDR_CTRL, (b == 2) ? 16'hF100 : 16'hE100);
			wreg(ADDR_BAUD, (b == 0) ? 16'h0800 : 16'h0100);
			wreg(ADDR_TX, 16'h0000);
			count_high(400);
			chk(cnt[15:0], (b == 2) ? 16'h017E : 16'h0070, "bit rate");
		end
		give_verdict();
	end
endmodule
